// [verilog/reference_control_pkg.sv]
// Purpose: Constants and types for the reference control register block
// Assumes: 8-bit special-function register bus from the processor core
// Notes:   Offsets, field positions and reset values live here only
`default_nettype none

package reference_control_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REFERENCE_CONTROL_ADDR = 8'hd1;
	localparam logic [7:0] REFERENCE_CONTROL_RESET = 8'h00;
	localparam logic [7:0] REFERENCE_CONTROL_MASK = 8'h0e;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int REF_SEL_BIT = 3;
	localparam int TEMP_EN_BIT = 2;
	localparam int BIAS_EN_BIT = 1;

	// Implemented control bits
	typedef struct packed {
		logic reference_source_select;
		logic temp_sensor_enable;
		logic bias_generator_enable;
	} ref_ctrl_t;

	// Special-function register access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

endpackage

`default_nettype wire

// [verilog/voltage_reference_control.sv]
// Purpose: Reference control register and analog enable outputs
// Assumes: Core accesses are synchronous to ref_clk_i, one cycle each
// Notes:   Read data is registered, so it appears one cycle after rd
`timescale 1ns/100ps
`default_nettype none

// How it works
// RULE1: Bits 7-4 and 0 read zero, writes ignored
// RULE2: Bit 3 selects external pin or supply
// RULE3: Bit 2 powers temperature sensor; off means invalid
// RULE4: Bias forced on by converter, sensor, oscillator
// RULE5: Software bias bit alone turns bias on
// RULE6: Software sets port pin analog and skipped
// RULE7: Reset clears all implemented bits
module voltage_reference_control
	import reference_control_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       sys_rst_i,
	// Register access from the core
	input  wire sfr_req_t   sfr_req_i,
	output logic [7:0]      sfr_rdata_o,
	output logic            sfr_hit_o,
	// Enables of dependent peripherals
	input  wire logic       converter_enable_i,
	input  wire logic       oscillator_enable_i,
	// Analog controls
	output logic            reference_source_select_o,
	output logic            temp_sensor_enable_o,
	output logic            temp_sensor_valid_o,
	output logic            bias_generator_enable_o
);

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	ref_ctrl_t ctrl_reg;
	logic      wr_hit;
	logic      rd_hit;

	// Reset image of the implemented fields, taken from the register reset byte
	localparam ref_ctrl_t CTRL_RESET = '{
		reference_source_select: REFERENCE_CONTROL_RESET[REF_SEL_BIT],
		temp_sensor_enable:      REFERENCE_CONTROL_RESET[TEMP_EN_BIT],
		bias_generator_enable:   REFERENCE_CONTROL_RESET[BIAS_EN_BIT]
	};

	// Address decode shared by the write and read paths
	function automatic logic addr_match(input logic [7:0] a);
		return a == REFERENCE_CONTROL_ADDR;
	endfunction

	// Any other address belongs to other registers on the same bus
	assign wr_hit = sfr_req_i.wr && addr_match(sfr_req_i.addr);
	assign rd_hit = sfr_req_i.rd && addr_match(sfr_req_i.addr);

	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			ctrl_reg <= CTRL_RESET; // see RULE7
		else if (wr_hit)
		begin
			// Only implemented bits are captured
			ctrl_reg.reference_source_select <= sfr_req_i.wdata[REF_SEL_BIT]; // see RULE2
			ctrl_reg.temp_sensor_enable      <= sfr_req_i.wdata[TEMP_EN_BIT]; // see RULE3
			ctrl_reg.bias_generator_enable   <= sfr_req_i.wdata[BIAS_EN_BIT]; // see RULE5
		end
	end

	// ----------------------------------------------------------------
	// Readback
	// ----------------------------------------------------------------
	function automatic logic [7:0] pack_ctrl(input ref_ctrl_t c, input logic bias);
		logic [7:0] v;
		v = 8'h00;
		v[REF_SEL_BIT] = c.reference_source_select;
		v[TEMP_EN_BIT] = c.temp_sensor_enable;
		v[BIAS_EN_BIT] = bias;
		return v & REFERENCE_CONTROL_MASK;
	endfunction

	// Bias bit reads the effective enable, so software sees a forced bias
	logic bias_next;
	assign bias_next = ctrl_reg.bias_generator_enable || converter_enable_i
		|| oscillator_enable_i || ctrl_reg.temp_sensor_enable; // see RULE4

	// Hit pulse marks the cycle in which read data stands
	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			sfr_hit_o <= 1'b0;
		else
			sfr_hit_o <= rd_hit;
	end

	// Data is zero outside a hit so the core can OR several sources
	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			sfr_rdata_o <= 8'h00;
		else if (rd_hit)
			sfr_rdata_o <= pack_ctrl(ctrl_reg, bias_next); // see RULE1
		else
			sfr_rdata_o <= 8'h00;
	end

	// ----------------------------------------------------------------
	// Analog outputs
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			reference_source_select_o <= 1'b0;
		else
			reference_source_select_o <= ctrl_reg.reference_source_select; // see RULE2
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			temp_sensor_enable_o <= 1'b0;
		else
			temp_sensor_enable_o <= ctrl_reg.temp_sensor_enable; // see RULE3
	end

	// Sensor output is only meaningful once both it and bias are up
	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			temp_sensor_valid_o <= 1'b0;
		else
			temp_sensor_valid_o <= ctrl_reg.temp_sensor_enable && bias_next; // see RULE3
	end

	// Forcing enables reach the bias pin one edge late; the analog side is slower
	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			bias_generator_enable_o <= 1'b0;
		else
			bias_generator_enable_o <= bias_next; // see RULE4 RULE5
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	unused_bits_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE1
		(sfr_rdata_o & ~REFERENCE_CONTROL_MASK) == 8'h00)
		else $error("unused reference bits read nonzero");

	source_follow_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE2
		wr_hit |=> ##1 reference_source_select_o == $past(sfr_req_i.wdata[REF_SEL_BIT], 2))
		else $error("reference select did not follow write");

	sensor_follow_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE3
		wr_hit |=> ##1 temp_sensor_enable_o == $past(sfr_req_i.wdata[TEMP_EN_BIT], 2))
		else $error("sensor enable did not follow write");

	sensor_valid_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE3
		!temp_sensor_enable_o |-> !temp_sensor_valid_o)
		else $error("sensor valid while off");

	bias_forced_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE4
		(converter_enable_i || oscillator_enable_i) |=> bias_generator_enable_o)
		else $error("bias not forced on");

	bias_manual_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE5
		(wr_hit && sfr_req_i.wdata[BIAS_EN_BIT]) |=> ##1 bias_generator_enable_o)
		else $error("manual bias write ignored");

	bias_off_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE5
		(!ctrl_reg.bias_generator_enable && !ctrl_reg.temp_sensor_enable
		&& !converter_enable_i && !oscillator_enable_i) |=> !bias_generator_enable_o)
		else $error("bias on without cause");

	reset_clear_a: assert property (@(posedge ref_clk_i) // see RULE7
		$fell(sys_rst_i) |-> ctrl_reg == '0)
		else $error("control not cleared by reset");

	reset_outputs_a: assert property (@(posedge ref_clk_i) // see RULE7
		$fell(sys_rst_i) |-> !reference_source_select_o && !temp_sensor_enable_o
		&& !temp_sensor_valid_o && !bias_generator_enable_o)
		else $error("outputs not cleared by reset");

	sensor_bias_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE4
		ctrl_reg.temp_sensor_enable |=> bias_generator_enable_o)
		else $error("bias not forced by sensor");

	bias_readback_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE4
		(rd_hit && (converter_enable_i || oscillator_enable_i)) |=> sfr_rdata_o[BIAS_EN_BIT])
		else $error("forced bias not visible on read");

	write_ignore_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE1
		!wr_hit |=> $stable(ctrl_reg))
		else $error("control changed without a write");

	field_capture_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE5
		wr_hit |=> ctrl_reg.bias_generator_enable == $past(sfr_req_i.wdata[BIAS_EN_BIT]))
		else $error("bias bit not captured");

	read_fields_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE2
		rd_hit |=> sfr_rdata_o[REF_SEL_BIT] == $past(ctrl_reg.reference_source_select)
		&& sfr_rdata_o[TEMP_EN_BIT] == $past(ctrl_reg.temp_sensor_enable))
		else $error("read data does not match control");

	read_hit_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE1
		rd_hit |=> sfr_hit_o && (sfr_rdata_o[0] == 1'b0))
		else $error("read hit pulse missing");

	read_idle_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE1
		!rd_hit |=> (sfr_rdata_o == 8'h00) && !sfr_hit_o)
		else $error("read data outside a hit");

	valid_match_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE3
		temp_sensor_valid_o == (temp_sensor_enable_o && bias_generator_enable_o))
		else $error("sensor valid disagrees with enables");

	sensor_off_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE3
		!ctrl_reg.temp_sensor_enable |=> !temp_sensor_valid_o)
		else $error("sensor valid while disabled");

	select_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // see RULE2
		!wr_hit |=> ##1 $stable(reference_source_select_o))
		else $error("reference select moved without a write");

endmodule // voltage_reference_control

`default_nettype wire

// [test/tb_voltage_reference_control.sv]
// Purpose: Self-checking bench for the reference control register
// Assumes: Inputs change on the falling edge of ref_clk_i
// Notes:   Bias read-back is the effective enable, so forcing shows in rdata
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb_voltage_reference_control
	import reference_control_pkg::*;
;
	logic       ref_clk_i           = 1'b0;
	logic       sys_rst_i           = 1'b1;
	sfr_req_t   sfr_req_i           = '0;
	logic       converter_enable_i  = 1'b0;
	logic       oscillator_enable_i = 1'b0;
	logic [7:0] sfr_rdata_o;
	logic       sfr_hit_o, sel_o, temp_o, valid_o, bias_o;
	int         n_mismatch          = 0;
	int         samples_checked     = 0;

	voltage_reference_control i_voltage_reference_control (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sfr_req_i(sfr_req_i),
		.sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
		.converter_enable_i(converter_enable_i), .oscillator_enable_i(oscillator_enable_i),
		.reference_source_select_o(sel_o), .temp_sensor_enable_o(temp_o),
		.temp_sensor_valid_o(valid_o), .bias_generator_enable_o(bias_o));

	initial
	begin
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	task automatic summarize();
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Write lands in the outputs two edges later, so wait both before returning
	task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge ref_clk_i);
		sfr_req_i = '{1'b1, 1'b0, addr, data};
		@(negedge ref_clk_i);
		sfr_req_i = '0;
		@(negedge ref_clk_i);
	endtask

	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		@(negedge ref_clk_i);
		sfr_req_i = '{1'b0, 1'b1, addr, 8'h00};
		@(negedge ref_clk_i);
		sfr_req_i = '0;
		`CHK("hit", (addr === REFERENCE_CONTROL_ADDR), sfr_hit_o)
		`CHK("rdata", exp, sfr_rdata_o)
	endtask

	// Expected nibble is {select, sensor, valid, bias}
	task automatic step(input logic cv, input logic os, input logic [7:0] wd,
		input logic [3:0] e);
		converter_enable_i  = cv;
		oscillator_enable_i = os;
		wr_reg(REFERENCE_CONTROL_ADDR, wd);
		`CHK("outputs", e, {sel_o, temp_o, valid_o, bias_o})
		rd_chk(REFERENCE_CONTROL_ADDR, {4'h0, e[3], e[2], e[0], 1'b0});
	endtask

	initial
	begin
		repeat (16) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		`CHK("reset", 4'h0, {sel_o, temp_o, valid_o, bias_o})
		rd_chk(REFERENCE_CONTROL_ADDR, 8'h00);
		step(1'b0, 1'b0, 8'hff, 4'hf);
		step(1'b0, 1'b0, 8'h08, 4'h8);
		// External reference from here; port pin setup is software's
		step(1'b0, 1'b0, 8'h02, 4'h1);
		step(1'b0, 1'b0, 8'h04, 4'h7);
		step(1'b1, 1'b0, 8'hf1, 4'h1);
		step(1'b0, 1'b1, 8'h00, 4'h1);
		step(1'b0, 1'b0, 8'h00, 4'h0);
		wr_reg(8'hd0, 8'hff);
		`CHK("other addr", 4'h0, {sel_o, temp_o, valid_o, bias_o})
		rd_chk(8'hd2, 8'h00);
		step(1'b0, 1'b0, 8'h0e, 4'hf);
		sys_rst_i = 1'b1;
		@(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		`CHK("mid reset", 4'h0, {sel_o, temp_o, valid_o, bias_o})
		rd_chk(REFERENCE_CONTROL_ADDR, 8'h00);
		summarize();
	end

	// About 70 cycles of traffic; a hang far past that is a failure
	initial
	begin
		repeat (2000) @(posedge ref_clk_i);
		n_mismatch++;
		summarize();
	end
endmodule // tb_voltage_reference_control
`default_nettype wire
